//--- verilog/scmc_top.sv
// System clock mode control: clock registers, wait and stop mode sequencing
`timescale 1ns/1ps

// Summary of operation
// - Peripheral clock gated in wait mode when the gate bit is 1.
// - Main oscillator halt acts only while an internal oscillator is selected.
// - Divide-by-8 bit forces CPU divide by 8, else divider field applies.
// - Entering stop mode sets the divide-by-8 bit.
// - All-clock halt enters stop mode and disables the feedback resistor.
// - Oscillator pin function bit, once 1, stays 1 until reset.
// - Slow oscillator off writable to 1 only while main clock selected.
// - Divider field: 00 none, 01 by 2, 10 by 4, 11 by 16.
// - Wait request stops CPU clock, oscillators keep running.
// - Interrupt ends wait, clears the wait bit; reset also ends it.
// - No-division on wait entry clears divide-by-8 and the divider field.
// - Exit selector: 00 keep, 01 reserved, 10 fast internal, 11 main.
// - Exit selector 10 sets internal source, fast enable and fast select.
// - Exit selector 11 clears main halt, sets pin function, selects main.
// - Source select bit; set automatically on main stop with detection 11.
module scmc_top
  import scmc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [scmc_pkg::SCMC_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic wake_irq,
  input wire logic main_clk_stop_det,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic wait_mode,
  output logic stop_mode,
  output logic main_osc_halt,
  output logic feedback_res_off,
  output logic osc_pin_function_sel,
  output logic slow_osc_off,
  output logic cpu_src_synth_sel,
  output logic internal_osc_source_sel,
  output logic stop_detect_enable,
  output logic stop_detect_irq_enable,
  output logic fast_osc_enable,
  output logic fast_osc_select
);
  import scmc_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  scmc_reg_if rb ();

  scmc_mode_t mode_reg;
  logic [7:0] clk_ctrl_reg_a;
  logic [7:0] clk_ctrl_reg_b;
  logic [7:0] clk_ctrl_reg_c;
  logic [7:0] write_protect_reg;
  logic [7:0] osc_stop_detect_reg;
  logic [7:0] fast_osc_ctrl_reg;
  logic [7:0] status_word;
  logic clock_reg_unlock;
  logic wr_a;
  logic wr_b;
  logic wr_c;
  logic wr_detect;
  logic wr_fast;
  logic enter_wait;
  logic enter_stop;
  logic leaving;
  logic exit_fast;
  logic exit_main;
  logic nodiv_on_entry;
  logic auto_switch;
  logic [1:0] div_field;
  logic [2:0] cpu_shift;

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  scmc_apb_slave u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .paddr(paddr),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pwdata(pwdata),
    .pready(pready),
    .prdata(prdata),
    .pslverr(pslverr),
    .rb(rb)
  );

  // ****************************************************************
  // Write strobes
  // ****************************************************************
  assign clock_reg_unlock = write_protect_reg[P_UNLOCK];

  // Locked writes are dropped silently; the bus still completes normally
  assign wr_a = rb.wr_en && (rb.idx == SCMC_IDX_CTRL_A) && clock_reg_unlock;
  assign wr_b = rb.wr_en && (rb.idx == SCMC_IDX_CTRL_B) && clock_reg_unlock;
  assign wr_c = rb.wr_en && (rb.idx == SCMC_IDX_CTRL_C) && clock_reg_unlock;
  assign wr_detect = rb.wr_en && (rb.idx == SCMC_IDX_DETECT) && clock_reg_unlock;
  assign wr_fast = rb.wr_en && (rb.idx == SCMC_IDX_FAST) && clock_reg_unlock;

  // ****************************************************************
  // Mode events
  // ****************************************************************
  assign enter_stop = (mode_reg == SCMC_RUN) && wr_b && rb.wdata[B_ALL_HALT];
  assign enter_wait = (mode_reg == SCMC_RUN) && wr_c && rb.wdata[C_WAIT]
                      && !enter_stop;
  // No-division is taken from the same write that requests wait
  assign nodiv_on_entry = enter_wait && rb.wdata[C_NODIV];
  assign leaving = (mode_reg != SCMC_RUN) && wake_irq;
  // Code 01 is reserved and treated like 00
  assign exit_fast = leaving
                     && (clk_ctrl_reg_c[C_EXIT_HI:C_EXIT_LO] == SCMC_EXIT_FAST);
  assign exit_main = leaving
                     && (clk_ctrl_reg_c[C_EXIT_HI:C_EXIT_LO] == SCMC_EXIT_MAIN);
  assign auto_switch = main_clk_stop_det
                       && (osc_stop_detect_reg[D_DET_IRQ:D_DET_EN] == SCMC_DET_AUTO);

  // ****************************************************************
  // Mode state machine
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= SCMC_RUN;
    end else begin
      unique case (mode_reg)
        SCMC_RUN: begin
          if (enter_stop) begin
            mode_reg <= SCMC_STOP;
          end else if (enter_wait) begin
            mode_reg <= SCMC_WAIT;
          end
        end
        SCMC_WAIT: begin
          if (wake_irq) begin
            mode_reg <= SCMC_RUN;
          end
        end
        SCMC_STOP: begin
          if (wake_irq) begin
            mode_reg <= SCMC_RUN;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Protect register
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_protect_reg <= 8'h00;
    end else if (rb.wr_en && (rb.idx == SCMC_IDX_PROTECT)) begin
      write_protect_reg <= {7'h00, rb.wdata[P_UNLOCK]};
    end
  end

  // ****************************************************************
  // Control register A
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_ctrl_reg_a <= SCMC_RST_A;
    end else begin
      if (wr_a) begin
        clk_ctrl_reg_a <= rb.wdata;
      end
      if (enter_stop) begin
        clk_ctrl_reg_a[A_DIV8] <= 1'b1;
      end
      if (nodiv_on_entry) begin
        clk_ctrl_reg_a[A_DIV8] <= 1'b0;
      end
      if (exit_main) begin
        clk_ctrl_reg_a[A_MAIN_HALT] <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Control register B
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_ctrl_reg_b <= SCMC_RST_B;
    end else begin
      if (wr_b) begin
        clk_ctrl_reg_b <= rb.wdata;
        // Pin function cannot be returned to general I/O by software
        clk_ctrl_reg_b[B_PIN_SEL] <= rb.wdata[B_PIN_SEL]
                                     | clk_ctrl_reg_b[B_PIN_SEL];
        clk_ctrl_reg_b[B_SLOW_OFF] <= rb.wdata[B_SLOW_OFF]
                                      && !internal_osc_source_sel;
      end
      // Cleared at the same edge that selects the internal source, so the two never overlap
      if (internal_osc_source_sel || exit_fast || auto_switch
          || (wr_detect && rb.wdata[D_INT_SRC])) begin
        clk_ctrl_reg_b[B_SLOW_OFF] <= 1'b0;
      end
      if (nodiv_on_entry) begin
        clk_ctrl_reg_b[B_DIV_HI:B_DIV_LO] <= 2'h0;
      end
      if (leaving) begin
        clk_ctrl_reg_b[B_ALL_HALT] <= 1'b0;
      end
      if (exit_main) begin
        clk_ctrl_reg_b[B_PIN_SEL] <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Control register C
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_ctrl_reg_c <= SCMC_RST_C;
    end else begin
      if (wr_c) begin
        clk_ctrl_reg_c <= rb.wdata & SCMC_MASK_C;
      end
      if (leaving) begin
        clk_ctrl_reg_c[C_WAIT] <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Oscillation stop detection control
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_stop_detect_reg <= 8'h00;
    end else begin
      if (wr_detect) begin
        osc_stop_detect_reg <= rb.wdata & SCMC_MASK_DETECT;
      end
      if (exit_main) begin
        osc_stop_detect_reg[D_INT_SRC] <= 1'b0;
      end
      if (exit_fast) begin
        osc_stop_detect_reg[D_INT_SRC] <= 1'b1;
      end
      // Detected stop wins over a same-cycle software clear
      if (auto_switch) begin
        osc_stop_detect_reg[D_INT_SRC] <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Fast internal oscillator control
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_osc_ctrl_reg <= 8'h00;
    end else begin
      if (wr_fast) begin
        fast_osc_ctrl_reg <= rb.wdata & SCMC_MASK_FAST;
      end
      if (exit_fast) begin
        fast_osc_ctrl_reg[F_FAST_EN] <= 1'b1;
        fast_osc_ctrl_reg[F_FAST_SEL] <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // CPU clock divider
  // ****************************************************************
  assign div_field = clk_ctrl_reg_b[B_DIV_HI:B_DIV_LO];

  always_comb begin
    if (clk_ctrl_reg_a[A_DIV8]) begin
      cpu_shift = SCMC_SHIFT_DIV8;
    end else if (div_field == 2'h3) begin
      cpu_shift = SCMC_SHIFT_DIV16;
    end else begin
      cpu_shift = {1'b0, div_field};
    end
  end

  // The CPU clock simply stops outside run mode
  scmc_cpu_div u_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(mode_reg == SCMC_RUN),
    .shift(cpu_shift),
    .cpu_clk_en(cpu_clk_en)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign wait_mode = (mode_reg == SCMC_WAIT);
  assign stop_mode = (mode_reg == SCMC_STOP);
  assign periph_clk_en = (mode_reg == SCMC_RUN)
                         || (wait_mode && !clk_ctrl_reg_a[A_PERIPH_GATE]);
  // The bit alone does not mean the main oscillator has stopped
  assign main_osc_halt = clk_ctrl_reg_a[A_MAIN_HALT] && internal_osc_source_sel;
  assign feedback_res_off = clk_ctrl_reg_b[B_FB_OFF] || stop_mode;
  assign osc_pin_function_sel = clk_ctrl_reg_b[B_PIN_SEL];
  assign slow_osc_off = clk_ctrl_reg_b[B_SLOW_OFF];
  assign cpu_src_synth_sel = clk_ctrl_reg_a[A_SYNTH];
  assign internal_osc_source_sel = osc_stop_detect_reg[D_INT_SRC];
  assign stop_detect_enable = osc_stop_detect_reg[D_DET_EN];
  assign stop_detect_irq_enable = osc_stop_detect_reg[D_DET_IRQ];
  assign fast_osc_enable = fast_osc_ctrl_reg[F_FAST_EN];
  assign fast_osc_select = fast_osc_ctrl_reg[F_FAST_SEL];

  // ****************************************************************
  // Register read mux
  // ****************************************************************
  assign status_word = {4'h0, main_clk_stop_det, clock_reg_unlock, stop_mode, wait_mode};

  always_comb begin
    rb.hit = 1'b1;
    unique case (rb.idx)
      SCMC_IDX_CTRL_A: rb.rdata = clk_ctrl_reg_a;
      SCMC_IDX_CTRL_B: rb.rdata = clk_ctrl_reg_b;
      SCMC_IDX_CTRL_C: rb.rdata = clk_ctrl_reg_c;
      SCMC_IDX_PROTECT: rb.rdata = write_protect_reg;
      SCMC_IDX_DETECT: rb.rdata = osc_stop_detect_reg;
      SCMC_IDX_FAST: rb.rdata = fast_osc_ctrl_reg;
      SCMC_IDX_STATUS: rb.rdata = status_word;
      default: begin
        rb.rdata = 8'h00;
        rb.hit = 1'b0;
      end
    endcase
  end

endmodule : scmc_top

//--- verilog/scmc_pkg.sv
// Constants and types shared by the system clock mode control block
package scmc_pkg;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam int unsigned SCMC_ADDR_W = 12;
  localparam logic [7:0] SCMC_IDX_CTRL_A = 8'h06;
  localparam logic [7:0] SCMC_IDX_CTRL_B = 8'h07;
  localparam logic [7:0] SCMC_IDX_CTRL_C = 8'h09;
  localparam logic [7:0] SCMC_IDX_PROTECT = 8'h0A;
  localparam logic [7:0] SCMC_IDX_DETECT = 8'h0C;
  localparam logic [7:0] SCMC_IDX_FAST = 8'h0D;
  localparam logic [7:0] SCMC_IDX_STATUS = 8'h0E;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned A_PERIPH_GATE = 2;
  localparam int unsigned A_MAIN_HALT = 5;
  localparam int unsigned A_DIV8 = 6;
  localparam int unsigned A_SYNTH = 7;
  localparam int unsigned B_ALL_HALT = 0;
  localparam int unsigned B_FB_OFF = 1;
  localparam int unsigned B_PIN_SEL = 3;
  localparam int unsigned B_SLOW_OFF = 4;
  localparam int unsigned B_DIV_LO = 6;
  localparam int unsigned B_DIV_HI = 7;
  localparam int unsigned C_WAIT = 0;
  localparam int unsigned C_NODIV = 5;
  localparam int unsigned C_EXIT_LO = 6;
  localparam int unsigned C_EXIT_HI = 7;
  localparam int unsigned P_UNLOCK = 0;
  localparam int unsigned D_DET_EN = 0;
  localparam int unsigned D_DET_IRQ = 1;
  localparam int unsigned D_INT_SRC = 2;
  localparam int unsigned F_FAST_EN = 0;
  localparam int unsigned F_FAST_SEL = 1;

  // ****************************************************************
  // Reset values and writable masks
  // ****************************************************************
  localparam logic [7:0] SCMC_RST_A = 8'h28;
  localparam logic [7:0] SCMC_RST_B = 8'h20;
  localparam logic [7:0] SCMC_RST_C = 8'h00;
  localparam logic [7:0] SCMC_MASK_C = 8'hF9;
  localparam logic [7:0] SCMC_MASK_DETECT = 8'h07;
  localparam logic [7:0] SCMC_MASK_FAST = 8'h03;

  // ****************************************************************
  // Encodings
  // ****************************************************************
  localparam logic [1:0] SCMC_EXIT_KEEP = 2'h0;
  localparam logic [1:0] SCMC_EXIT_FAST = 2'h2;
  localparam logic [1:0] SCMC_EXIT_MAIN = 2'h3;
  localparam logic [1:0] SCMC_DET_AUTO = 2'h3;
  localparam logic [2:0] SCMC_SHIFT_DIV8 = 3'h3;
  localparam logic [2:0] SCMC_SHIFT_DIV16 = 3'h4;

  typedef enum logic [1:0] {SCMC_RUN, SCMC_WAIT, SCMC_STOP} scmc_mode_t;

endpackage : scmc_pkg

//--- verilog/scmc_reg_if.sv
// Internal register access carrier between bus slave and control core
`timescale 1ns/1ps
interface scmc_reg_if;
  logic wr_en;
  logic [7:0] idx;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic hit;
  modport bus (output wr_en, output idx, output wdata, input rdata, input hit);
  modport regs (input wr_en, input idx, input wdata, output rdata, output hit);
endinterface : scmc_reg_if

//--- verilog/scmc_apb_slave.sv
// APB slave front end: decode, one-wait-free access, registered read data
`timescale 1ns/1ps
module scmc_apb_slave
  import scmc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [scmc_pkg::SCMC_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  scmc_reg_if.bus rb
);
  import scmc_pkg::*;

  logic addr_ok;
  logic err_reg;
  logic [31:0] rdata_reg;

  // Unaligned or out-of-map words are refused with an error
  assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[SCMC_ADDR_W-1:10] == '0) && rb.hit;
  assign rb.idx = paddr[9:2];
  assign rb.wdata = pwdata[7:0];
  assign rb.wr_en = psel && penable && pwrite && addr_ok;
  assign pready = 1'b1;
  assign prdata = rdata_reg;
  assign pslverr = err_reg && penable;

  // Read data is latched in the setup cycle so it comes from a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= 32'h0;
      err_reg <= 1'b0;
    end else if (psel && !penable) begin
      rdata_reg <= (pwrite || !addr_ok) ? 32'h0 : {24'h0, rb.rdata};
      err_reg <= !addr_ok;
    end
  end

endmodule : scmc_apb_slave

//--- verilog/scmc_cpu_div.sv
// CPU clock enable divider: one pulse every 2**shift cycles while running
`timescale 1ns/1ps
module scmc_cpu_div
  import scmc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [2:0] shift,
  output logic cpu_clk_en
);
  import scmc_pkg::*;

  logic [3:0] cnt_reg;
  logic [3:0] limit;

  assign limit = 4'((5'h01 << shift) - 5'h01);

  // A ratio change restarts cleanly because a count at or above a lowered limit wraps at the next edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 4'h0;
      cpu_clk_en <= 1'b0;
    end else if (!run) begin
      cnt_reg <= 4'h0;
      cpu_clk_en <= 1'b0;
    end else if (cnt_reg >= limit) begin
      cnt_reg <= 4'h0;
      cpu_clk_en <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
      cpu_clk_en <= 1'b0;
    end
  end

endmodule : scmc_cpu_div

//--- verif/scmc_props.sv
// Concurrent checks on the clock mode control top-level ports
`timescale 1ns/1ps
module scmc_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wake_irq,
  input wire logic main_clk_stop_det,
  input wire logic cpu_clk_en,
  input wire logic periph_clk_en,
  input wire logic wait_mode,
  input wire logic stop_mode,
  input wire logic main_osc_halt,
  input wire logic feedback_res_off,
  input wire logic osc_pin_function_sel,
  input wire logic slow_osc_off,
  input wire logic internal_osc_source_sel,
  input wire logic stop_detect_enable,
  input wire logic stop_detect_irq_enable
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************************************************************
  // Properties
  // ****************************************************************
  property p_halt_src;
    main_osc_halt |-> internal_osc_source_sel;
  endproperty
  a_halt_src: assert property (p_halt_src) else $error("main halt without internal source");
  property p_stop_fb;
    $rose(stop_mode) |-> feedback_res_off && !periph_clk_en;
  endproperty
  a_stop_fb: assert property (p_stop_fb) else $error("stop entry left clocks or resistor on");
  property p_cpu_idle;
    (wait_mode || stop_mode) [*2] |-> !cpu_clk_en;
  endproperty
  a_cpu_idle: assert property (p_cpu_idle) else $error("cpu enable pulsed while halted");
  property p_wake;
    (wait_mode || stop_mode) && wake_irq |=> !wait_mode && !stop_mode;
  endproperty
  a_wake: assert property (p_wake) else $error("interrupt did not end low power mode");
  property p_hold_wait;
    wait_mode && !wake_irq |=> wait_mode;
  endproperty
  a_hold_wait: assert property (p_hold_wait) else $error("wait ended without interrupt");
  property p_slow;
    internal_osc_source_sel |-> !slow_osc_off;
  endproperty
  a_slow: assert property (p_slow) else $error("slow oscillator off with internal source");
  property p_pin;
    osc_pin_function_sel |=> osc_pin_function_sel;
  endproperty
  a_pin: assert property (p_pin) else $error("pin function bit cleared");
  property p_run_periph;
    !wait_mode && !stop_mode |-> periph_clk_en;
  endproperty
  a_run_periph: assert property (p_run_periph) else $error("peripheral clock off in run");
  property p_auto;
    main_clk_stop_det && stop_detect_enable && stop_detect_irq_enable |=> internal_osc_source_sel;
  endproperty
  a_auto: assert property (p_auto) else $error("no switch to internal source");
  c_wait: cover property ($rose(wait_mode));
  c_stop: cover property ($rose(stop_mode));
  c_auto: cover property ($rose(internal_osc_source_sel));
endmodule : scmc_props

//--- verif/scmc_top_bench.sv
// Self-checking bench for the system clock mode control block
`timescale 1ns/1ps
module scmc_top_bench;
  import scmc_pkg::*;
  localparam logic [11:0] AA = {2'h0, SCMC_IDX_CTRL_A, 2'h0};
  localparam logic [11:0] AB = {2'h0, SCMC_IDX_CTRL_B, 2'h0};
  localparam logic [11:0] AC = {2'h0, SCMC_IDX_CTRL_C, 2'h0};
  localparam logic [11:0] AP = {2'h0, SCMC_IDX_PROTECT, 2'h0};
  localparam logic [11:0] AD = {2'h0, SCMC_IDX_DETECT, 2'h0};
  localparam logic [11:0] AF = {2'h0, SCMC_IDX_FAST, 2'h0};
  localparam logic [11:0] AS = {2'h0, SCMC_IDX_STATUS, 2'h0};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic wake_irq = 1'b0;
  logic main_clk_stop_det = 1'b0;
  logic pready, pslverr, cpu_clk_en, periph_clk_en, wait_mode, stop_mode, main_osc_halt;
  logic feedback_res_off, osc_pin_function_sel, slow_osc_off, cpu_src_synth_sel;
  logic internal_osc_source_sel, stop_detect_enable, stop_detect_irq_enable;
  logic fast_osc_enable, fast_osc_select, rd_err;
  logic [31:0] prdata, rd_val;
  int n_errors = 0;
  int num_checks = 0;
  int gaps [4] = '{1, 2, 4, 16};
  always #4 pclk = ~pclk;
  scmc_top DUT (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .prdata,
    .pslverr, .wake_irq, .main_clk_stop_det, .cpu_clk_en, .periph_clk_en, .wait_mode,
    .stop_mode, .main_osc_halt, .feedback_res_off, .osc_pin_function_sel, .slow_osc_off,
    .cpu_src_synth_sel, .internal_osc_source_sel, .stop_detect_enable,
    .stop_detect_irq_enable, .fast_osc_enable, .fast_osc_select);
  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd_val = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(a, 1'b1, {24'h0, d});
    // Outputs are looked at only once the write has settled
    @(negedge pclk);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string nm);
    xfer(a, 1'b0, 32'h0);
    chk(nm, rd_val, {24'h0, exp});
  endtask : rd
  // Skips a settling span so a ratio change from the previous setting is not measured
  task automatic gap(input int exp);
    int n;
    n = 0;
    repeat (40) @(negedge pclk);
    while (cpu_clk_en !== 1'b1 && n < 40) begin
      n++;
      @(negedge pclk);
    end
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (cpu_clk_en !== 1'b1 && n < 40);
    chk("cpu_gap", n, exp);
  endtask : gap
  task automatic wake();
    @(posedge pclk);
    wake_irq <= 1'b1;
    @(posedge pclk);
    wake_irq <= 1'b0;
    @(negedge pclk);
  endtask : wake
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(AA, 8'h28, "ctrl_a");
    rd(AB, 8'h20, "ctrl_b");
    rd(AC, 8'h00, "ctrl_c");
    wr(AA, 8'hFF);
    rd(AA, 8'h28, "locked_a");
    xfer(12'h03C, 1'b0, 32'h0);
    chk("unmapped_err", rd_err, 1);
    wr(AP, 8'h01);
    chk("halt_main_src", main_osc_halt, 0);
    for (int i = 0; i < 4; i++) begin
      wr(AB, {i[1:0], 6'h20});
      gap(gaps[i]);
    end
    wr(AA, 8'h68);
    gap(8);
    chk("synth_off", cpu_src_synth_sel, 0);
    wr(AA, 8'h6C);
    wr(AC, 8'h21);
    @(negedge pclk);
    chk("wait", wait_mode, 1);
    chk("periph_gated", periph_clk_en, 0);
    rd(AA, 8'h2C, "nodiv_a");
    rd(AB, 8'h20, "nodiv_b");
    wake();
    chk("wait_exit", wait_mode, 0);
    rd(AC, 8'h20, "wait_bit_clear");
    wr(AA, 8'h28);
    wr(AC, 8'h01);
    chk("periph_kept", periph_clk_en, 1);
    wake();
    wr(AC, 8'h81);
    wake();
    rd(AD, 8'h04, "exit_fast_detect");
    rd(AF, 8'h03, "exit_fast_osc");
    chk("fast_pins", {fast_osc_select, fast_osc_enable}, 32'h3);
    chk("halt_int_src", main_osc_halt, 1);
    wr(AB, 8'h30);
    chk("slow_forced_on", slow_osc_off, 0);
    wr(AC, 8'hC1);
    wake();
    rd(AA, 8'h08, "exit_main_a");
    rd(AB, 8'h28, "exit_main_b");
    rd(AD, 8'h00, "exit_main_detect");
    wr(AB, 8'h38);
    chk("slow_off", slow_osc_off, 1);
    wr(AB, 8'h20);
    rd(AB, 8'h28, "pin_sticky");
    wr(AC, 8'h41);
    wake();
    rd(AA, 8'h08, "exit_reserved");
    wr(AC, 8'h00);
    wr(AB, 8'h21);
    @(negedge pclk);
    chk("stop", stop_mode, 1);
    chk("stop_fb", feedback_res_off, 1);
    rd(AA, 8'h48, "stop_div8");
    wake();
    chk("stop_exit", stop_mode, 0);
    rd(AB, 8'h28, "stop_bit_clear");
    wr(AD, 8'h03);
    @(posedge pclk);
    main_clk_stop_det <= 1'b1;
    repeat (2) @(negedge pclk);
    chk("auto_src", internal_osc_source_sel, 1);
    rd(AD, 8'h07, "auto_detect");
    chk("det_pins", {stop_detect_irq_enable, stop_detect_enable}, 32'h3);
    rd(AS, 8'h0C, "status");
    wr(AD, 8'h04);
    wr(AA, 8'h68);
    wr(AB, 8'h2A);
    chk("ext_fb", feedback_res_off, 1);
    chk("ext_halt", main_osc_halt, 1);
    wr(AP, 8'h00);
    wr(AB, 8'h60);
    rd(AB, 8'h2A, "relocked_b");
    finish_test();
  end
  initial begin
    #200000;
    n_errors++;
    finish_test();
  end
endmodule : scmc_top_bench
bind scmc_top scmc_props u_props (.pclk, .presetn, .wake_irq, .main_clk_stop_det, .cpu_clk_en,
  .periph_clk_en, .wait_mode, .stop_mode, .main_osc_halt, .feedback_res_off,
  .osc_pin_function_sel, .slow_osc_off, .internal_osc_source_sel, .stop_detect_enable,
  .stop_detect_irq_enable);
